// >>> design/seq_pkg.sv
// constants and types of the trigger and memory sequencer
//
// Contract
// R1 - binary results carry no delimiter
// R2 - short check after detection time, 1-100 ms
// R3 - retry switchable, interval 1-50 ms
// R4 - system reset restores defaults, then saves
// R5 - continuous: back to wait, internal free-runs
// R6 - not continuous: go idle after measuring
// R7 - idle ignores triggers; only arm leaves (a read leaves idle too)
// R8 - continuous off remote only; on at exit
// R9 - arm while continuous gives execution error
// R10 - single shot: one trigger, one measurement
// R11 - external source forces auto memory off
// R12 - trigger to measurement delay 0-100 ms
// R13 - external trigger edge is selectable
// R14 - positive text sign is a space
// R15 - latest-value query never triggers
// R16 - read arms from idle, returns next value
// R17 - read rejected if continuous or waiting
// R18 - read holds off commands until done
// R19 - memory holds up to 30000 results
// R20 - memory mode change erases stored results
// R21 - auto memory forces internal, statistics on
// R22 - host lifts probes before detection time ends
// R23 - end output: hold until start or pulse
// R24 - state register resets to wait, continuous
package seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;       // 100 mhz system clock
  localparam int unsigned TIME_UNIT_NS  = 1000000;  // times are set in 1 ms steps
  localparam int unsigned CYC_PER_UNIT  = TIME_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned MEM_DEPTH     = 30000;    // result entries
  localparam int          MEM_AW        = 15;       // index width
  localparam int          VAL_W         = 32;       // result width
  localparam int          TW            = 7;        // time field width (ms)
  localparam logic [TW-1:0] SHORT_MIN = 7'h01;      // 0.001 s
  localparam logic [TW-1:0] SHORT_MAX = 7'h64;      // 0.1 s
  localparam logic [TW-1:0] RETRY_MIN = 7'h01;      // 0.001 s
  localparam logic [TW-1:0] RETRY_MAX = 7'h32;      // 0.05 s
  localparam logic [TW-1:0] DELAY_MAX = 7'h64;      // 0.100 s
  localparam logic [TW-1:0] EOM_MIN   = 7'h01;      // pulse width bounds
  localparam logic [TW-1:0] EOM_MAX   = 7'h64;
  localparam logic [7:0]    SIGN_POS  = 8'h20;      // space for positive
  localparam logic [7:0]    SIGN_NEG  = 8'h2d;      // minus
  localparam logic [7:0]    DELIM     = 8'h0a;      // text delimiter

  // host command codes
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_SET_CONT = 5'h01, OP_ARM = 5'h02, OP_SET_SRC = 5'h03,
    OP_SET_DELAY = 5'h04, OP_SET_EDGE = 5'h05, OP_SET_FMT = 5'h06, OP_SET_MEM = 5'h07,
    OP_SET_EOM_MODE = 5'h08, OP_SET_EOM_W = 5'h09, OP_SET_SHORT = 5'h0a,
    OP_SET_SHORT_T = 5'h0b, OP_SET_RETRY = 5'h0c, OP_SET_RETRY_T = 5'h0d,
    OP_FETCH = 5'h0e, OP_READ = 5'h0f, OP_SYS_RESET = 5'h10, OP_MEM_CLEAR = 5'h11
  } op_t;

  typedef enum logic [1:0] {MEM_OFF = 2'h0, MEM_STORE = 2'h1, MEM_AUTO = 2'h2} mem_mode_t;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_WAIT = 5'h02, ST_DELAY = 5'h04, ST_MEAS = 5'h08, ST_RETRY = 5'h10
  } state_t;

  typedef struct packed { op_t op; logic [15:0] arg; } cmd_t;
  typedef struct packed { logic fault; logic [VAL_W-1:0] value; } meas_t;
  typedef struct packed {
    logic binary; logic [7:0] sign_char; logic [VAL_W-1:0] magnitude;
    logic delim_en; logic [7:0] delim;
  } result_t;
  typedef struct packed {
    logic cont; logic src_ext; logic edge_fall; logic fmt_bin; logic short_en;
    logic retry_en; logic eom_pulse; logic stats_en; mem_mode_t mem_mode;
    logic [TW-1:0] delay_ms; logic [TW-1:0] eom_ms; logic [TW-1:0] short_ms;
    logic [TW-1:0] retry_ms;
  } settings_t;

  localparam settings_t SET_DEFAULT = '{cont: 1'b1, src_ext: 1'b0, edge_fall: 1'b0,
    fmt_bin: 1'b0, short_en: 1'b0, retry_en: 1'b0, eom_pulse: 1'b0, stats_en: 1'b0,
    mem_mode: MEM_OFF, delay_ms: 7'h00, eom_ms: EOM_MIN, short_ms: SHORT_MIN,
    retry_ms: RETRY_MIN};
endpackage : seq_pkg

// >>> design/ms_timer.sv
// one-shot timer counting whole time-unit ticks
`timescale 1ns/100ps
`default_nettype none
module ms_timer
  import seq_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          tick,
  input  wire logic          start,
  input  wire logic [TW-1:0] load,
  output logic               busy,
  output logic               expire
);
  logic [TW-1:0] cnt_q;  // units left
  logic          run_q;  // running flag

  // expire once the remaining count has run out
  assign expire = run_q && (cnt_q == '0);
  assign busy   = run_q;

  // load on start, count down on each tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= load;
        run_q <= 1'b1;
      end else if (expire) begin
        run_q <= 1'b0;
      end else if (run_q && tick) begin
        cnt_q <= cnt_q - 7'h01;
      end
    end
  end
endmodule : ms_timer
`default_nettype wire

// >>> design/pin_edge.sv
// two-stage synchroniser with edge detect for a pin
`timescale 1ns/100ps
`default_nettype none
module pin_edge (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic s1_q;  // first stage, read only by s2
  logic s2_q;  // settled level
  logic s3_q;  // previous settled level

  // synchronise, then keep one history bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q && !s3_q;
  assign fall = !s2_q && s3_q;
endmodule : pin_edge
`default_nettype wire

// >>> design/trigger_and_memory_sequencer.sv
// measurement sequencer: trigger states, delay, end output, results and memory
`timescale 1ns/100ps
`default_nettype none
module trigger_and_memory_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_UNIT  // cycles per 1 ms step
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire cmd_t              cmd,
  input  wire logic              remote_active,
  input  wire logic              auto_range_en,
  input  wire logic              ext_start_input,
  output logic                   meas_start,
  output logic                   meas_autorange,
  input  wire logic              meas_done,
  input  wire meas_t             meas,
  output logic                   measure_done_output,
  output logic                   probe_short_check,
  output logic                   resp_valid,
  output result_t                resp,
  output logic                   exec_err,
  output logic                   nv_store,
  output logic                   stats_en,
  output logic [MEM_AW-1:0]      mem_count,
  input  wire logic [MEM_AW-1:0] mem_rd_idx,
  output logic [VAL_W-1:0]       mem_rd_data,
  output state_t                 seq_state
);
  //////////////////////////////////////////////////////////////////////////////
  // reset release and time base

  logic rst_a_q, rst_n;  // reset release chain

  // release reset through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n   <= rst_a_q;
    end
  end

  logic [31:0] pre_q;  // ms prescaler
  logic        tick;   // one pulse per ms
  assign tick = (pre_q == CYC_PER_MS - 1);

  // free running millisecond tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pre_q <= '0;
    else if (clk_en) pre_q <= tick ? '0 : pre_q + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  state_t    state_q, state_d;  // sequencer state
  settings_t set_q;             // live settings
  logic      read_pend_q;       // read waiting for its result
  logic      acc;               // command taken this cycle
  logic      is_arm, is_read, arm_err, read_err;
  logic      complete;          // measurement finished for good
  logic      ext_start_input_ev;           // qualified trigger in wait
  logic      ext_rise, ext_fall;
  logic      dly_exp, rty_exp, eom_exp, sh_exp, sh_busy;

  assign cmd_ready = !read_pend_q;  // [R18]
  assign acc       = clk_en && cmd_valid && cmd_ready;
  assign is_arm    = acc && (cmd.op == OP_ARM);
  assign is_read   = acc && (cmd.op == OP_READ);
  assign arm_err   = is_arm && set_q.cont;  // [R9]
  assign read_err  = is_read && (set_q.cont || state_q == ST_WAIT);  // [R17]
  assign complete  = (state_q == ST_MEAS) && meas_done && !(meas.fault && set_q.retry_en);

  //////////////////////////////////////////////////////////////////////////////
  // trigger input

  pin_edge u_ext_start_input (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (clk_en),
    .pin     (ext_start_input),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  // internal source fires at once, external on the chosen edge
  assign ext_start_input_ev = set_q.src_ext ? (set_q.edge_fall ? ext_fall : ext_rise) : 1'b1;  // [R13]

  //////////////////////////////////////////////////////////////////////////////
  // state machine

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        // only an arm or a read leaves idle; triggers are ignored
        if ((is_arm && !arm_err) || (is_read && !read_err)) state_d = ST_WAIT;  // [R7] [R16]
      end
      ST_WAIT: begin
        if (ext_start_input_ev) state_d = ST_DELAY;  // [R10]
      end
      ST_DELAY: begin
        if (dly_exp) state_d = ST_MEAS;  // [R12]
      end
      ST_MEAS: begin
        if (complete) state_d = set_q.cont ? ST_WAIT : ST_IDLE;  // [R5] [R6]
        else if (meas_done) state_d = ST_RETRY;  // [R3]
      end
      ST_RETRY: begin
        if (rty_exp) state_d = ST_MEAS;
      end
    endcase
  end

  // state register, resets to waiting for a trigger
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) state_q <= ST_WAIT;  // [R24]
    else if (clk_en) state_q <= state_d;
  end
  assign seq_state = state_q;

  // start of each measurement attempt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meas_start     <= 1'b0;
      meas_autorange <= 1'b0;
    end else if (clk_en) begin
      meas_start     <= (state_q != ST_MEAS) && (state_d == ST_MEAS);
      // best range first when auto ranging
      meas_autorange <= auto_range_en;  // [R16]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timers

  ms_timer u_delay (
    .clk_sys (clk_sys), .rst_n (rst_n), .ce (clk_en), .tick (tick),
    .start   ((state_q == ST_WAIT) && ext_start_input_ev),
    .load    (set_q.delay_ms), .busy (), .expire (dly_exp)
  );

  ms_timer u_retry (
    .clk_sys (clk_sys), .rst_n (rst_n), .ce (clk_en), .tick (tick),
    .start   ((state_q == ST_MEAS) && meas_done && !complete),
    .load    (set_q.retry_ms), .busy (), .expire (rty_exp)
  );

  ms_timer u_eom (
    .clk_sys (clk_sys), .rst_n (rst_n), .ce (clk_en), .tick (tick),
    .start   (complete), .load (set_q.eom_ms), .busy (), .expire (eom_exp)
  );

  ms_timer u_short (
    .clk_sys (clk_sys), .rst_n (rst_n), .ce (clk_en), .tick (tick),
    .start   (complete && set_q.short_en),
    .load    (set_q.short_ms), .busy (sh_busy), .expire (sh_exp)
  );

  // short check only after the detection time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) probe_short_check <= 1'b0;
    else if (clk_en) probe_short_check <= sh_exp;  // [R2] [R22]
  end

  // end output: hold until next start, or pulse width
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) measure_done_output <= 1'b0;
    else if (clk_en) begin
      if (complete) measure_done_output <= 1'b1;  // [R23]
      else if (set_q.eom_pulse ? eom_exp : meas_start) measure_done_output <= 1'b0;  // [R23]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // settings

  logic ok_t;  // argument accepted: time in range, continuous-off rule, legal memory mode
  always_comb begin
    ok_t = 1'b1;
    unique case (cmd.op)
      OP_SET_DELAY:   ok_t = cmd.arg <= {9'h0, DELAY_MAX};
      OP_SET_EOM_W:   ok_t = cmd.arg >= {9'h0, EOM_MIN} && cmd.arg <= {9'h0, EOM_MAX};
      OP_SET_SHORT_T: ok_t = cmd.arg >= {9'h0, SHORT_MIN} && cmd.arg <= {9'h0, SHORT_MAX};
      OP_SET_RETRY_T: ok_t = cmd.arg >= {9'h0, RETRY_MIN} && cmd.arg <= {9'h0, RETRY_MAX};
      OP_SET_CONT:    ok_t = cmd.arg[0] || remote_active;  // [R8]
      OP_SET_MEM:     ok_t = cmd.arg[1:0] != 2'h3;
      default:        ok_t = 1'b1;
    endcase
  end

  logic remote_q;  // previous remote level
  logic mem_clr;   // erase stored results
  settings_t set_d;

  // settings after this cycle's command
  always_comb begin
    set_d = set_q;
    if (acc && ok_t) begin
      unique case (cmd.op)
        OP_SET_CONT:     set_d.cont = cmd.arg[0];
        OP_SET_SRC: begin
          set_d.src_ext = cmd.arg[0];
          if (cmd.arg[0] && set_q.mem_mode == MEM_AUTO) set_d.mem_mode = MEM_OFF;  // [R11]
        end
        OP_SET_DELAY:    set_d.delay_ms = cmd.arg[TW-1:0];  // [R12]
        OP_SET_EDGE:     set_d.edge_fall = cmd.arg[0];  // [R13]
        OP_SET_FMT:      set_d.fmt_bin = cmd.arg[0];
        OP_SET_MEM: begin
          set_d.mem_mode = mem_mode_t'(cmd.arg[1:0]);
          if (cmd.arg[1:0] == MEM_AUTO) begin
            set_d.src_ext  = 1'b0;  // [R21]
            set_d.stats_en = 1'b1;  // [R21]
          end
        end
        OP_SET_EOM_MODE: set_d.eom_pulse = cmd.arg[0];
        OP_SET_EOM_W:    set_d.eom_ms = cmd.arg[TW-1:0];
        OP_SET_SHORT:    set_d.short_en = cmd.arg[0];
        OP_SET_SHORT_T:  set_d.short_ms = cmd.arg[TW-1:0];  // [R2]
        OP_SET_RETRY:    set_d.retry_en = cmd.arg[0];  // [R3]
        OP_SET_RETRY_T:  set_d.retry_ms = cmd.arg[TW-1:0];  // [R3]
        OP_SYS_RESET: begin
          set_d         = SET_DEFAULT;  // [R4]
          set_d.fmt_bin = set_q.fmt_bin;  // communication setting kept
        end
        default: set_d = set_q;
      endcase
    end
    // leaving remote turns continuous back on
    if (remote_q && !remote_active) set_d.cont = 1'b1;  // [R8]
  end

  assign mem_clr = (set_d.mem_mode != set_q.mem_mode) || (acc && cmd.op == OP_MEM_CLEAR);  // [R20]

  // settings register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      set_q    <= SET_DEFAULT;
      remote_q <= 1'b0;
    end else if (clk_en) begin
      set_q    <= set_d;
      remote_q <= remote_active;
    end
  end
  assign stats_en = set_q.stats_en;

  // error and backup pulses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exec_err <= 1'b0;
      nv_store <= 1'b0;
    end else if (clk_en) begin
      exec_err <= arm_err || read_err || (acc && !ok_t);  // [R9] [R17]
      nv_store <= acc && (cmd.op == OP_SYS_RESET);  // [R4]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // results

  logic [VAL_W-1:0] last_q;  // latest finished value

  // format one result for the host
  function automatic result_t fmt(input logic [VAL_W-1:0] v, input logic bin);
    result_t r;
    r.binary    = bin;
    r.magnitude = bin ? v : (v[VAL_W-1] ? VAL_W'(-v) : v);
    r.sign_char = v[VAL_W-1] ? SIGN_NEG : SIGN_POS;  // [R14]
    r.delim_en  = !bin;  // [R1]
    r.delim     = DELIM;
    return r;
  endfunction : fmt

  // latest value and read hold-off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_q      <= '0;
      read_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (complete) last_q <= meas.value;
      if (complete) read_pend_q <= 1'b0;
      else if (is_read && !read_err) read_pend_q <= 1'b1;  // [R18]
    end
  end

  // answers to fetch and read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp       <= '0;
    end else if (clk_en) begin
      resp_valid <= 1'b0;
      if (complete && read_pend_q) begin
        resp_valid <= 1'b1;  // [R16]
        resp       <= fmt(meas.value, set_q.fmt_bin);
      end else if (acc && cmd.op == OP_FETCH) begin
        resp_valid <= 1'b1;  // [R15]
        resp       <= fmt(last_q, set_q.fmt_bin);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result memory

  logic [VAL_W-1:0] mem_q [MEM_DEPTH];  // stored results
  logic             mem_wr;

  assign mem_wr = complete && (set_q.mem_mode != MEM_OFF) && !mem_clr
                  && (mem_count < MEM_AW'(MEM_DEPTH));  // [R19]

  // entry count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) mem_count <= '0;
    else if (clk_en) begin
      if (mem_clr) mem_count <= '0;  // [R20]
      else if (mem_wr) mem_count <= mem_count + 15'h1;
    end
  end

  // storage and read port
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (mem_wr) mem_q[mem_count] <= meas.value;
      mem_rd_data <= (mem_rd_idx < MEM_AW'(MEM_DEPTH)) ? mem_q[mem_rd_idx] : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  property p_bin_nodelim;
    @(posedge clk_sys) disable iff (!rst_n) resp_valid && resp.binary |-> !resp.delim_en;
  endproperty
  a_bin_nodelim: assert property (p_bin_nodelim) else $error("delimiter in binary"); // [R1]

  property p_pos_sign;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && complete && read_pend_q && !set_q.fmt_bin && !meas.value[VAL_W-1]
      |=> resp_valid && resp.sign_char == SIGN_POS && resp.delim_en;
  endproperty
  a_pos_sign: assert property (p_pos_sign) else $error("positive sign not space"); // [R14]

  property p_cont_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && complete && set_q.cont |=> state_q == ST_WAIT;
  endproperty
  a_cont_wait: assert property (p_cont_wait) else $error("no return to wait"); // [R5]

  property p_single_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && complete && !set_q.cont |=> state_q == ST_IDLE;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("no return to idle"); // [R6]

  property p_idle_stay;
    @(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_IDLE && !is_arm && !is_read |=> state_q == ST_IDLE;
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("idle left without arm"); // [R7]

  property p_arm_err;
    @(posedge clk_sys) disable iff (!rst_n)
      is_arm && set_q.cont |=> exec_err && $stable(set_q.cont);
  endproperty
  a_arm_err: assert property (p_arm_err) else $error("arm not rejected"); // [R9]

  property p_read_err;
    @(posedge clk_sys) disable iff (!rst_n)
      is_read && state_q == ST_WAIT |=> exec_err && !read_pend_q;
  endproperty
  a_read_err: assert property (p_read_err) else $error("read not rejected"); // [R17]

  property p_hold_off;
    @(posedge clk_sys) disable iff (!rst_n) read_pend_q |-> !cmd_ready;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("command taken during read"); // [R18]

  property p_ext_auto;
    @(posedge clk_sys) disable iff (!rst_n) !(set_q.src_ext && set_q.mem_mode == MEM_AUTO);
  endproperty
  a_ext_auto: assert property (p_ext_auto) else $error("auto memory with ext source"); // [R11]

  property p_eom_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && measure_done_output && !set_q.eom_pulse && !meas_start && !complete
      |=> measure_done_output;
  endproperty
  a_eom_hold: assert property (p_eom_hold) else $error("end output dropped early"); // [R23]

  property p_short_time;
    @(posedge clk_sys) disable iff (!rst_n) probe_short_check |-> $past(sh_busy);
  endproperty
  a_short_time: assert property (p_short_time) else $error("short check too early"); // [R2]

  c_free_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
    complete && set_q.cont ##[1:20] meas_start);
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    read_pend_q ##[1:50] resp_valid);
  c_retry: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == ST_RETRY);
endmodule : trigger_and_memory_sequencer
`default_nettype wire

// >>> sim/front_end_model.sv
// front end model: answers every start pulse with one result after a set latency
`timescale 1ns/100ps
`default_nettype none
module front_end_model
  import seq_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             meas_start,
  input  wire logic [7:0]       lat,
  input  wire logic [VAL_W-1:0] val,
  output logic                  meas_done,
  output meas_t                 meas
);
  int unsigned cnt;  // cycles left before answering, 0 when idle
  initial begin
    meas_done = 1'b0;
    meas = '0;
    cnt = 0;
  end
  // one done pulse per start; probes count as lifted at done
  always @(posedge clk_sys) begin
    meas_done <= 1'b0;
    meas <= ~meas;  // junk between answers: the last answer and its inverse alternate
    if (meas_start) begin
      cnt <= lat + 1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        meas_done <= 1'b1;
        meas <= '{fault: 1'b0, value: val};
      end
    end
  end
endmodule : front_end_model
`default_nettype wire

// >>> sim/trigger_and_memory_sequencer_bench.sv
// self-checking bench of the trigger and memory sequencer
`timescale 1ns/100ps
`default_nettype none
module trigger_and_memory_sequencer_bench import seq_pkg::*;;
  logic clk_sys = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, clk_en = 1'b1;
  logic remote_active = 1'b1, auto_range_en = 1'b0, ext_start_input = 1'b0;
  logic [MEM_AW-1:0] mem_rd_idx = '0;
  cmd_t cmd = '0;
  logic [7:0] lat = 8'h03;  // front end latency
  logic [VAL_W-1:0] val = 32'h00000005;
  logic cmd_ready, meas_start, meas_done, measure_done_output, probe_short_check;
  logic resp_valid, exec_err, nv_store, stats_en, rv, er, ns, meas_autorange, ar;
  logic [VAL_W-1:0] rd_data;  // memory read port
  meas_t meas;
  result_t resp;
  logic [MEM_AW-1:0] mem_count;
  state_t seq_state;
  int err_count = 0, cmp_count = 0, cyc = 0, starts = 0, n, n0, t_done, t_psc;
  trigger_and_memory_sequencer #(.CYC_PER_MS(10)) dut (.clk_sys, .reset_n, .clk_en,
    .cmd_valid, .cmd_ready, .cmd, .remote_active, .auto_range_en, .ext_start_input,
    .meas_start, .meas_autorange, .meas_done, .meas, .measure_done_output,
    .probe_short_check, .resp_valid, .resp, .exec_err, .nv_store, .stats_en,
    .mem_count, .mem_rd_idx, .mem_rd_data(rd_data), .seq_state);
  front_end_model fe (.clk_sys, .meas_start, .lat, .val, .meas_done, .meas);
  always #5 clk_sys = ~clk_sys;
  // cycle count, start count, timing marks and hang limit
  always @(posedge clk_sys) begin
    cyc++;
    starts += meas_start;
    if (meas_start) ar = meas_autorange;
    if (meas_done) t_done = cyc;
    if (probe_short_check) t_psc = cyc;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // one command word, held until cmd_ready is seen; answers sampled one cycle later
  task automatic send(input op_t op, input logic [15:0] arg);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd = '{op: op, arg: arg};
    while (!cmd_ready) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    er = exec_err;
    rv = resp_valid;
    ns = nv_store;
  endtask : send
  task automatic wait_st(input state_t s, input int lim);
    n = 0;
    while (seq_state !== s && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_st
  task automatic pin_to(input logic v);
    @(negedge clk_sys);
    ext_start_input = v;
    repeat (6) @(negedge clk_sys);
  endtask : pin_to
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h7c92d882));
    repeat (10) @(negedge clk_sys);
    chk("reset state", seq_state, ST_WAIT);
    reset_n = 1'b1;
    repeat (200) @(negedge clk_sys);
    chk("free run", starts > 3, 1);
    send(OP_SET_MEM, 16'h0001);
    repeat (100) @(negedge clk_sys);
    chk("stored", mem_count > 0, 1);
    chk("mem data", rd_data, val);
    send(OP_SET_MEM, 16'h0002);
    chk("mode erase", mem_count, 0);
    chk("stats on", stats_en, 1);
    send(OP_ARM, 16'h0000);
    chk("arm err", er, 1);
    send(OP_READ, 16'h0000);
    chk("read err", er, 1);
    send(OP_SET_DELAY, 16'h0065);
    chk("delay err", er, 1);
    remote_active = 1'b0;
    send(OP_SET_CONT, 16'h0000);
    chk("local err", er, 1);
    remote_active = 1'b1;
    send(OP_SET_CONT, 16'h0000);
    wait_st(ST_IDLE, 100);
    chk("idle after", seq_state, ST_IDLE);
    clk_en = 1'b0;
    send(OP_ARM, 16'h0000);
    chk("frozen", seq_state, ST_IDLE);
    clk_en = 1'b1;
    send(OP_SET_SRC, 16'h0001);
    n0 = starts;
    pin_to(1'b1);
    pin_to(1'b0);
    chk("idle ignores", starts - n0, 0);
    val = $urandom & 32'h7fffffff;
    send(OP_ARM, 16'h0000);
    pin_to(1'b1);
    wait_st(ST_IDLE, 100);
    chk("one shot", starts - n0, 1);
    chk("ext mem off", mem_count, 0);
    chk("end hold", measure_done_output, 1);
    n0 = starts;
    send(OP_FETCH, 16'h0000);
    chk("fetch value", resp.magnitude, val);
    chk("fetch no ext_start_input", starts - n0, 0);
    chk("sign space", resp.sign_char, 8'h20);
    send(OP_SET_FMT, 16'h0001);
    send(OP_FETCH, 16'h0000);
    chk("bin no delim", {rv, resp.binary, resp.delim_en}, 3'b110);
    send(OP_SET_EDGE, 16'h0001);
    send(OP_SET_DELAY, 16'h0003);
    send(OP_SET_SHORT, 16'h0001);
    send(OP_SET_SHORT_T, 16'h0002);
    pin_to(1'b0);
    send(OP_ARM, 16'h0000);
    pin_to(1'b1);
    chk("rise ignored", seq_state, ST_WAIT);
    pin_to(1'b0);
    wait_st(ST_MEAS, 100);
    chk("delay span", n >= 13 && n <= 40, 1);
    wait_st(ST_IDLE, 100);
    repeat (40) @(negedge clk_sys);
    chk("short time", t_psc - t_done >= 9 && t_psc - t_done <= 32, 1);
    send(OP_SET_SRC, 16'h0000);
    lat = 8'($urandom_range(1, 9));
    val = $urandom & 32'h7fffffff;
    auto_range_en = 1'b1;
    send(OP_READ, 16'h0000);
    chk("read holds", cmd_ready, 0);
    n = 0;
    while (resp_valid !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk("read value", resp.magnitude, val);
    chk("read idle", seq_state, ST_IDLE);
    chk("auto range", ar, 1);
    send(OP_SYS_RESET, 16'h0000);
    chk("backup", ns, 1);
    send(OP_ARM, 16'h0000);
    chk("cont default", er, 1);
    wrap_up();
  end
endmodule : trigger_and_memory_sequencer_bench
`default_nettype wire
